// ---- fmw_pkg.sv ----
// Constants and carrier types for the frame memory window access block.
package fmw_pkg;

  localparam logic [7:0] CMD_COL_WINDOW = 8'h2a;
  localparam logic [7:0] CMD_ROW_WINDOW = 8'h2b;
  localparam logic [7:0] CMD_FRAME_WRITE = 8'h2c;
  localparam logic [7:0] CMD_FRAME_READ = 8'h2e;

  localparam logic [15:0] PTR_ZERO = 16'h0000;
  localparam logic [15:0] LIMIT_LONG = 16'h013f;
  localparam logic [15:0] LIMIT_SHORT = 16'h00ef;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  localparam int ORIENT_BIT = 5;
  localparam int COL_MIRROR_BIT = 6;
  localparam int ROW_MIRROR_BIT = 7;
  localparam int PIX_W = 18;
  localparam logic [1:0] PARAM_LAST = 2'h3;
  localparam logic [1:0] PARAM_STEP = 2'h1;

  localparam logic [7:0] OFS_ORIENT = 8'h00;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h04;
  localparam logic [7:0] OFS_ROW_WIN = 8'h08;
  localparam logic [7:0] OFS_COL_WIN = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNTERS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PARAM = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ = 4'b1000
  } mode_t;

  typedef struct packed {
    logic cmd_data_select;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [PIX_W-1:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [15:0] start_ptr;
    logic [15:0] end_ptr;
  } window_t;

endpackage

// ---- frame_store.sv ----
// Flip-flop frame memory with one write port and a registered read port.
module frame_store
  import fmw_pkg::*;
#(
  parameter int WIDTH = PIX_W,
  parameter int ADDR_W = 17,
  parameter int DEPTH = 102400
)
(
  // Clock and enable
  input wire logic aclk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (2 ** ADDR_W) || DEPTH < 1)
  begin : g_bad_depth
    $error("Frame store depth does not fit its address width.");
  end

  // Pixels have no reset, so no reset of any kind disturbs the picture.
  always_ff @(posedge aclk)
  begin
    if (ce)
    begin
      if (we && (32'(addr) < DEPTH))
      begin
        mem[addr] <= wdata;
      end
      rdata <= (32'(addr) < DEPTH) ? mem[addr] : '0;
    end
  end

endmodule

// ---- frame_window_access.sv ----
// Host command interpreter for windowed frame memory writes and reads.
module frame_window_access
  import fmw_pkg::*;
#(
  parameter int MEM_DIM = int'(LIMIT_LONG) + 1,
  parameter int ADDR_W = 17
)
(
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Host parallel port
  input wire host_pins_t host_pins,
  output logic [PIX_W-1:0] host_data_out,
  output logic host_data_oe_n,
  // AXI4-Lite write channels
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  typedef struct packed {
    host_pins_t sync1;
    host_pins_t sync2;
    logic prev_wr_n;
    logic prev_rd_n;
    mode_t mode;
    logic [7:0] cmd;
    logic [1:0] pidx;
    logic [7:0] hi_byte;
    window_t col_win;
    window_t row_win;
    logic [15:0] col;
    logic [15:0] row;
    logic [7:0] orient;
    logic dummy_pending;
    logic [PIX_W-1:0] dout;
    logic drive;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic wr_rise, rd_fall, rd_rise, cmd_take, data_take, rd_take, advance;
  logic mem_we, in_range, soft_rst;
  logic [7:0] byte_in;
  logic [15:0] col_lim, row_lim, pcol, prow, col_step, row_step;
  logic [ADDR_W-1:0] mem_addr;
  logic [PIX_W-1:0] mem_rdata;

  if (MEM_DIM <= int'(LIMIT_LONG) || MEM_DIM * MEM_DIM > (2 ** ADDR_W))
  begin : g_bad_dim
    $error("Frame memory dimension cannot hold the largest window.");
  end

  // Strobe edges are taken from the second synchroniser stage only.
  assign wr_rise = st_reg.sync2.write_strobe_n & ~st_reg.prev_wr_n;
  assign rd_fall = ~st_reg.sync2.read_strobe_n & st_reg.prev_rd_n;
  assign rd_rise = st_reg.sync2.read_strobe_n & ~st_reg.prev_rd_n;
  assign cmd_take = ce & wr_rise & ~st_reg.sync2.cmd_data_select;
  assign data_take = ce & wr_rise & st_reg.sync2.cmd_data_select;
  assign rd_take = ce & rd_fall & st_reg.sync2.cmd_data_select & (st_reg.mode == ST_READ);
  assign byte_in = st_reg.sync2.data[7:0];

  // The orientation bit swaps which axis may reach the long limit.
  assign col_lim = st_reg.orient[ORIENT_BIT] ? LIMIT_LONG : LIMIT_SHORT;
  assign row_lim = st_reg.orient[ORIENT_BIT] ? LIMIT_SHORT : LIMIT_LONG;
  assign in_range = (st_reg.col <= col_lim) && (st_reg.row <= row_lim);

  // Mirroring the physical address moves the starting corner.
  assign pcol = st_reg.orient[COL_MIRROR_BIT] ? col_lim - st_reg.col : st_reg.col;
  assign prow = st_reg.orient[ROW_MIRROR_BIT] ? row_lim - st_reg.row : st_reg.row;
  assign mem_addr = ADDR_W'(32'(prow) * MEM_DIM + 32'(pcol));

  // One scan step serves both directions, so writes and reads walk alike.
  always_comb
  begin
    col_step = st_reg.col;
    row_step = st_reg.row;
    if (!st_reg.orient[ORIENT_BIT])
    begin
      if (st_reg.col == st_reg.col_win.end_ptr)
      begin
        col_step = st_reg.col_win.start_ptr;
        row_step = (st_reg.row == st_reg.row_win.end_ptr) ?
                   st_reg.row_win.start_ptr : st_reg.row + PTR_STEP;
      end
      else
      begin
        col_step = st_reg.col + PTR_STEP;
      end
    end
    else
    begin
      if (st_reg.row == st_reg.row_win.end_ptr)
      begin
        row_step = st_reg.row_win.start_ptr;
        col_step = (st_reg.col == st_reg.col_win.end_ptr) ?
                   st_reg.col_win.start_ptr : st_reg.col + PTR_STEP;
      end
      else
      begin
        row_step = st_reg.row + PTR_STEP;
      end
    end
  end

  assign advance = (data_take && st_reg.mode == ST_WRITE) || (rd_take && !st_reg.dummy_pending);

  always_comb
  begin
    st_next = st_reg;
    mem_we = 1'b0;
    soft_rst = 1'b0;
    st_next.sync1 = host_pins;
    st_next.sync2 = st_reg.sync1;
    st_next.prev_wr_n = st_reg.sync2.write_strobe_n;
    st_next.prev_rd_n = st_reg.sync2.read_strobe_n;
    // No power state gates the decoder.
    if (cmd_take)
    begin
      st_next.cmd = byte_in;
      st_next.pidx = '0;
      st_next.dummy_pending = 1'b0;
      unique case (byte_in)
        CMD_COL_WINDOW, CMD_ROW_WINDOW: st_next.mode = ST_PARAM;
        CMD_FRAME_WRITE:
        begin
          st_next.mode = ST_WRITE;
          st_next.col = st_reg.col_win.start_ptr;
          st_next.row = st_reg.row_win.start_ptr;
        end
        CMD_FRAME_READ:
        begin
          st_next.mode = ST_READ;
          st_next.dummy_pending = 1'b1;
          st_next.col = st_reg.col_win.start_ptr;
          st_next.row = st_reg.row_win.start_ptr;
        end
        default: st_next.mode = ST_IDLE;
      endcase
    end
    else if (data_take)
    begin
      unique case (st_reg.mode)
        ST_PARAM:
        begin
          st_next.pidx = st_reg.pidx + PARAM_STEP;
          if (!st_reg.pidx[0])
          begin
            st_next.hi_byte = byte_in;
          end
          else if (st_reg.cmd == CMD_ROW_WINDOW)
          begin
            // Only row pointers change here.
            if (st_reg.pidx == PARAM_LAST)
            begin
              st_next.row_win.end_ptr = {st_reg.hi_byte, byte_in};
            end
            else
            begin
              st_next.row_win.start_ptr = {st_reg.hi_byte, byte_in};
            end
          end
          else
          begin
            if (st_reg.pidx == PARAM_LAST)
            begin
              st_next.col_win.end_ptr = {st_reg.hi_byte, byte_in};
            end
            else
            begin
              st_next.col_win.start_ptr = {st_reg.hi_byte, byte_in};
            end
          end
          if (st_reg.pidx == PARAM_LAST)
          begin
            st_next.mode = ST_IDLE;
          end
        end
        ST_WRITE:
        begin
          // No word count is kept, so streams run on without limit.
          mem_we = in_range;
        end
        default: st_next.mode = st_reg.mode;
      endcase
    end
    if (advance)
    begin
      st_next.col = col_step;
      st_next.row = row_step;
    end
    if (rd_take)
    begin
      st_next.drive = 1'b1;
      st_next.dout = st_reg.dummy_pending ? '0 : mem_rdata;
      st_next.dummy_pending = 1'b0;
    end
    if (rd_rise)
    begin
      st_next.drive = 1'b0;
    end
    // Write address and data may arrive in either order.
    if (awvalid && awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = awaddr[7:0];
    end
    if (wvalid && wready)
    begin
      st_next.w_got = 1'b1;
      st_next.wr_data = wdata;
      st_next.wr_strb = wstrb;
    end
    if (st_reg.bvalid && bready)
    begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.aw_addr)
        OFS_ORIENT:
        begin
          if (st_reg.wr_strb[0])
          begin
            st_next.orient = st_reg.wr_data[7:0];
          end
        end
        OFS_SOFT_RESET: soft_rst = st_reg.wr_strb[0] & st_reg.wr_data[0];
        OFS_ROW_WIN, OFS_COL_WIN, OFS_STATUS, OFS_COUNTERS: st_next.bresp = RESP_OKAY;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      unique case (araddr[7:0])
        OFS_ORIENT: st_next.rdata = {24'h000000, st_reg.orient};
        OFS_SOFT_RESET: st_next.rdata = '0;
        OFS_ROW_WIN: st_next.rdata = st_reg.row_win;
        OFS_COL_WIN: st_next.rdata = st_reg.col_win;
        OFS_STATUS: st_next.rdata = {16'h0000, st_reg.cmd, 3'h0, st_reg.dummy_pending,
                                     st_reg.mode};
        OFS_COUNTERS: st_next.rdata = {st_reg.row, st_reg.col};
        default:
        begin
          st_next.rdata = '0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Soft reset keeps the orientation, since the end defaults depend on it.
    if (soft_rst)
    begin
      st_next.mode = ST_IDLE;
      st_next.pidx = '0;
      st_next.drive = 1'b0;
      st_next.dummy_pending = 1'b0;
      st_next.row_win = {PTR_ZERO, row_lim};
      st_next.col_win = {PTR_ZERO, col_lim};
    end
    if (!aresetn)
    begin
      st_next = '0;
      st_next.sync1.write_strobe_n = 1'b1;
      st_next.sync1.read_strobe_n = 1'b1;
      st_next.sync2.write_strobe_n = 1'b1;
      st_next.sync2.read_strobe_n = 1'b1;
      st_next.prev_wr_n = 1'b1;
      st_next.prev_rd_n = 1'b1;
      st_next.mode = ST_IDLE;
      st_next.row_win = {PTR_ZERO, LIMIT_LONG};
      st_next.col_win = {PTR_ZERO, LIMIT_SHORT};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (ce || !aresetn)
    begin
      st_reg <= st_next;
    end
  end

  frame_store #(.WIDTH(PIX_W), .ADDR_W(ADDR_W), .DEPTH(MEM_DIM * MEM_DIM)) u_store (
    .aclk(aclk),
    .ce(ce),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(st_reg.sync2.data),
    .rdata(mem_rdata)
  );

  // Ready terms drop with the clock enable so no handshake is lost in a freeze.
  assign awready = ce & ~st_reg.aw_got & ~st_reg.bvalid;
  assign wready = ce & ~st_reg.w_got & ~st_reg.bvalid;
  assign arready = ce & ~st_reg.rvalid;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign host_data_out = st_reg.dout;
  assign host_data_oe_n = ~st_reg.drive;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_row_last;
    data_take && st_reg.mode == ST_PARAM && st_reg.cmd == CMD_ROW_WINDOW &&
    st_reg.pidx == PARAM_LAST;
  endsequence
  sequence s_read_cmd;
    cmd_take && byte_in == CMD_FRAME_READ;
  endsequence
  sequence s_dummy_read;
    rd_take && st_reg.dummy_pending;
  endsequence

  a_row_cmd_code: assert property (cmd_take && byte_in == CMD_ROW_WINDOW |=>
    st_reg.mode == ST_PARAM && st_reg.cmd == CMD_ROW_WINDOW && st_reg.pidx == 2'h0)
    else $error("Row window command not decoded.");
  a_row_ptr_load: assert property (s_row_last |=> st_reg.row_win.end_ptr ==
    {$past(st_reg.hi_byte), $past(byte_in)} && st_reg.mode == ST_IDLE)
    else $error("End row pointer not loaded.");
  a_row_only: assert property (s_row_last |=> $stable(st_reg.col_win) &&
    $stable(st_reg.orient)) else $error("Row window disturbed other state.");
  a_write_reload: assert property (cmd_take && byte_in == CMD_FRAME_WRITE |=>
    st_reg.mode == ST_WRITE && st_reg.col == st_reg.col_win.start_ptr &&
    st_reg.row == st_reg.row_win.start_ptr) else $error("Write did not reload counters.");
  a_range_block: assert property (mem_we |-> st_reg.col <= col_lim &&
    st_reg.row <= row_lim) else $error("Out of range pixel stored.");
  a_soft_defaults: assert property (soft_rst && ce |=>
    st_reg.row_win.start_ptr == PTR_ZERO &&
    st_reg.row_win.end_ptr == (st_reg.orient[ORIENT_BIT] ? LIMIT_SHORT : LIMIT_LONG))
    else $error("Soft reset defaults wrong.");
  a_stream_end: assert property (cmd_take && st_reg.mode == ST_WRITE &&
    byte_in != CMD_FRAME_WRITE |=> st_reg.mode != ST_WRITE)
    else $error("Write stream survived a command.");
  a_col_wrap: assert property (advance && !st_reg.orient[ORIENT_BIT] &&
    st_reg.col == st_reg.col_win.end_ptr |=> st_reg.col == $past(st_reg.col_win.start_ptr))
    else $error("Column did not wrap to start.");
  a_read_dummy: assert property (s_read_cmd |=> st_reg.mode == ST_READ &&
    st_reg.dummy_pending) else $error("Read command did not arm the dummy word.");
  a_dummy_word: assert property (s_dummy_read |=> st_reg.dout == '0 &&
    st_reg.drive && !st_reg.dummy_pending) else $error("First read word is not the dummy.");

endmodule

// ---- host_model.sv ----
// Host processor model that drives the parallel command and pixel port.
module host_model
  import fmw_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Port toward the device
  output host_pins_t pins,
  input wire logic [PIX_W-1:0] dout,
  input wire logic oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pins = '{1'b1, 1'b1, 1'b1, 18'h00000};
  end
  // Released data lines show the inverse of the last word so a stale value never looks valid.
  task automatic put(input logic s, input logic [PIX_W-1:0] d);
    @(posedge aclk);
    pins.cmd_data_select <= s;
    pins.data <= d;
    pins.write_strobe_n <= 1'b0;
    repeat (4) @(posedge aclk);
    pins.write_strobe_n <= 1'b1;
    repeat (5) @(posedge aclk);
    pins.data <= ~d;
  endtask
  task automatic get(output logic [PIX_W-1:0] d, output logic oe);
    @(posedge aclk);
    pins.cmd_data_select <= 1'b1;
    pins.read_strobe_n <= 1'b0;
    repeat (6) @(posedge aclk);
    d = dout;
    oe = oe_n;
    pins.read_strobe_n <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
endmodule

// ---- frame_window_access_bench.sv ----
// Self-checking bench for the frame window access block.
module frame_window_access_bench
  import fmw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, oe_n, oe;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [3:0] wstrb;
  logic [PIX_W-1:0] dout, px;
  host_pins_t pins, bus;
  int num_errors, n_tests;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0000013f, 32'h000000ef, 32'h0};
  logic [1:0] rr [5] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
  // The data wire carries the device's word whenever it holds the bus.
  assign bus = oe_n ? pins : host_pins_t'{pins.cmd_data_select, pins.write_strobe_n,
    pins.read_strobe_n, dout};
  always #50 aclk = ~aclk;
  frame_window_access dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .host_pins(bus),
    .host_data_out(dout), .host_data_oe_n(oe_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  host_model host (.aclk(aclk), .pins(pins), .dout(dout), .oe_n(oe_n));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stuck();
    num_errors++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] s);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        s = bresp;
        break;
      end
    end
    if (i == 50)
      stuck();
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] s);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arvalid === 1'b1 && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        v = rdata;
        s = rresp;
        break;
      end
    end
    if (i == 50)
      stuck();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = RESP_OKAY, input logic [31:0] m = 32'hffffffff);
    axi_rd({24'h0, a}, d, r);
    chk(d & m, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    axi_wr({24'h0, a}, v, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic win(input logic [7:0] c, input logic [15:0] s, input logic [15:0] e);
    host.put(1'b0, {10'h0, c});
    host.put(1'b1, {10'h0, s[15:8]});
    host.put(1'b1, {10'h0, s[7:0]});
    host.put(1'b1, {10'h0, e[15:8]});
    host.put(1'b1, {10'h0, e[7:0]});
  endtask
  // Logical counters for pixel k in the window of columns 1..2 and rows 2..3.
  function automatic logic [31:0] cnt(input logic o, input int k);
    int i;
    i = k % 4;
    if (o)
      return {16'(2 + i % 2), 16'(1 + i / 2)};
    return {16'(2 + i / 2), 16'(1 + i % 2)};
  endfunction
  function automatic logic [PIX_W-1:0] pix(input logic o, input int k);
    return 18'h2a500 | {13'h0, o, 4'(k)};
  endfunction
  task automatic rstream(input logic o);
    win(CMD_COL_WINDOW, 16'h0001, 16'h0002);
    win(CMD_ROW_WINDOW, 16'h0002, 16'h0003);
    host.put(1'b0, {10'h0, CMD_FRAME_READ});
    rd(OFS_STATUS, {16'h0, CMD_FRAME_READ, 8'h08}, RESP_OKAY, 32'h0000ff0f);
    host.get(px, oe);
    chk({14'h0, px}, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      host.get(px, oe);
      chk({14'h0, px}, {14'h0, pix(o, k == 0 ? 4 : k)});
      chk({31'h0, oe}, 32'h0);
    end
  endtask
  task automatic wstream(input logic o);
    wr(OFS_ORIENT, {26'h0, o, 5'h0});
    win(CMD_COL_WINDOW, 16'h0001, 16'h0002);
    win(CMD_ROW_WINDOW, 16'h0002, 16'h0003);
    rd(OFS_ROW_WIN, 32'h00020003);
    rd(OFS_COL_WIN, 32'h00010002);
    host.put(1'b0, {10'h0, CMD_FRAME_WRITE});
    rd(OFS_STATUS, {16'h0, CMD_FRAME_WRITE, 8'h04}, RESP_OKAY, 32'h0000ff0f);
    rd(OFS_COUNTERS, cnt(o, 0));
    for (int k = 0; k < 5; k++)
    begin
      host.put(1'b1, pix(o, k));
      rd(OFS_COUNTERS, cnt(o, k + 1));
    end
    rstream(o);
    $display("stream test done, orientation %0d", o);
  endtask
  // Row 240 is legal in one orientation only, so a dropped pixel leaves the old word visible.
  task automatic drop_test();
    wr(OFS_ORIENT, 32'h0);
    win(CMD_COL_WINDOW, 16'h0001, 16'h0001);
    win(CMD_ROW_WINDOW, 16'h00f0, 16'h00f0);
    host.put(1'b0, {10'h0, CMD_FRAME_WRITE});
    host.put(1'b1, 18'h15a5a);
    wr(OFS_ORIENT, 32'h20);
    host.put(1'b0, {10'h0, CMD_FRAME_WRITE});
    host.put(1'b1, 18'h0f0f0);
    wr(OFS_ORIENT, 32'h0);
    host.put(1'b0, {10'h0, CMD_FRAME_READ});
    host.get(px, oe);
    host.get(px, oe);
    chk({14'h0, px}, 32'h00015a5a);
    chk({31'h0, oe_n}, 32'h1);
    host.put(1'b0, 18'h00000);
    rd(OFS_STATUS, 32'h00000001, RESP_OKAY, 32'h0000ff0f);
    // A strobe that comes and goes while the enable is low must not be seen.
    ce <= 1'b0;
    host.put(1'b0, {10'h0, CMD_FRAME_WRITE});
    ce <= 1'b1;
    rd(OFS_STATUS, 32'h00000001, RESP_OKAY, 32'h0000ff0f);
    $display("range and freeze test done");
  endtask
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    wstrb = 4'hf;
    {awaddr, wdata, araddr} = 96'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(ra[i], rv[i], rr[i]);
    chk({31'h0, oe_n}, 32'h1);
    $display("reset value test done");
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(OFS_ROW_WIN, 32'h12345678);
    rd(OFS_ROW_WIN, 32'h0000013f);
    $display("register access test done");
    wstream(1'b1);
    wstream(1'b0);
    win(CMD_ROW_WINDOW, 16'h0140, 16'h0140);
    rd(OFS_ROW_WIN, 32'h01400140);
    drop_test();
    wr(OFS_ORIENT, 32'h20);
    wr(OFS_SOFT_RESET, 32'h1);
    rd(OFS_ROW_WIN, 32'h000000ef);
    rd(OFS_COL_WIN, 32'h0000013f);
    rd(OFS_ORIENT, 32'h20);
    // A second hardware reset in mid-run must also leave the pixels in place.
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_ORIENT, 32'h0);
    wstrb <= 4'he;
    wr(OFS_ORIENT, 32'h20);
    wstrb <= 4'hf;
    rd(OFS_ORIENT, 32'h0);
    rstream(1'b0);
    $display("reset retention test done");
    end_of_test();
  end
endmodule
